// ---- ext_mem_pkg.sv ----
// constants, types and helpers shared by the external memory width adapter
// What this block does
// RULE1 - hub side treats every target as byte addressed, 24-bit external byte space
// RULE2 - eight-bit memory takes all generated byte address lines one to one
// RULE3 - sixteen-bit memory wires its lowest input to line one, line zero unused
// RULE4 - sixteen-bit transfers advance the byte address by two per word
// RULE5 - sixteen-bit memory uses two data ports, eight-bit memory exactly one
// RULE6 - no single-byte transfer on sixteen-bit memory, so no odd burst counts
// RULE7 - eight-bit core reaches sixteen-bit memory only by other means such as DMA; the adapter still passes its aligned half and word requests
// RULE8 - wide core issues no byte or unaligned access to sixteen-bit memory
// RULE9 - DMA to eight-bit memory always uses a burst count of one
// RULE10 - two-byte burst to eight-bit memory goes out as one transfer, not split
// RULE11 - eight-bit variant decodes the upper half of its data space as external memory
// RULE12 - eight-bit variant decodes control registers in a 256-byte window
// RULE13 - wide variant decodes a 16 MB external RAM window as external memory
// RULE14 - wide variant decodes control registers in a 256-byte peripheral window
// RULE15 - hub wait states follow the clock divider: reads 1,3,5,7, writes 2,4,6,8
// RULE16 - even byte on the low data port, odd byte on the high data port
`default_nettype none
package ext_mem_pkg;
  // ***************************************************************
  // widths and address windows
  // ***************************************************************
  localparam int MEM_ADDR_W = 24;
  localparam logic [31:0] EXT8_LO = 32'h0080_0000;
  localparam logic [31:0] EXT8_HI = 32'h00ff_ffff;
  localparam logic [31:0] CTRL8_LO = 32'h0000_5400;
  localparam logic [31:0] CTRL8_HI = 32'h0000_54ff;
  localparam logic [31:0] EXT32_LO = 32'h6000_0000;
  localparam logic [31:0] EXT32_HI = 32'h60ff_ffff;
  localparam logic [31:0] CTRL32_LO = 32'h4000_5400;
  localparam logic [31:0] CTRL32_HI = 32'h4000_54ff;
  localparam logic [23:0] ADDR_STEP16 = 24'h00_0002;

  // ***************************************************************
  // access sizes and wait states per divider code 0..3
  // ***************************************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [15:0] RD_WS_TABLE = 16'h7531;
  localparam logic [15:0] WR_WS_TABLE = 16'h8642;

  // one hub request
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
  } hub_req_t;

  // wait states of one beat for a divider code and direction
  function automatic logic [3:0] waits_for(input logic [1:0] div, input logic wr);
    logic [15:0] tbl;
    tbl = wr ? WR_WS_TABLE : RD_WS_TABLE;
    return tbl[{div, 2'b00} +: 4];
  endfunction

  // inclusive address window test
  function automatic logic in_window(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage
`default_nettype wire

// ---- ext_mem_wait_counter.sv ----
// wait state counter that times one memory beat
`default_nettype none
module ext_mem_wait_counter import ext_mem_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // beat control
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [1:0] div_in,
  output logic busy_out,
  output logic done_out
);
  logic [3:0] count;

  // load on start, count down to zero while busy
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 4'h0;
      busy_out <= 1'b0;
    end else if (start_in) begin
      count <= waits_for(div_in, write_in); // [RULE15]
      busy_out <= 1'b1;
    end else if (busy_out) begin
      if (count == 4'h0) begin
        busy_out <= 1'b0;
      end else begin
        count <= count - 4'h1;
      end
    end
  end

  // last cycle of the beat
  assign done_out = busy_out && (count == 4'h0);
endmodule
`default_nettype wire

// ---- ext_mem_width_adapter.sv ----
// hub-side address decode and data width adaptation for external memory
`default_nettype none
module ext_mem_width_adapter import ext_mem_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // static configuration
  input wire logic mem_width16_in,
  input wire logic cpu_wide_in,
  input wire logic [1:0] clk_div_in,
  // hub request
  input wire logic req_valid_in,
  input wire hub_req_t req_in,
  output logic req_ready_out,
  // hub answer
  output logic resp_valid_out,
  output logic resp_error_out,
  output logic [31:0] resp_rdata_out,
  // control register window
  output logic ctrl_access_out,
  output logic ctrl_write_out,
  output logic [7:0] ctrl_offset_out,
  output logic [7:0] ctrl_wdata_out,
  // external memory address and strobe
  output logic [23:0] mem_addr_out,
  output logic mem_strobe_out,
  output logic mem_write_out,
  // low data port
  input wire logic [7:0] data_lo_in,
  output logic [7:0] data_lo_out,
  output logic data_lo_oe_out,
  // high data port
  input wire logic [7:0] data_hi_in,
  output logic [7:0] data_hi_out,
  output logic data_hi_oe_out
);
  // ***************************************************************
  // state and decode
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BEAT = 2'b01,
    ST_RESP = 2'b10
  } state_t;

  state_t state;
  state_t next_state;
  hub_req_t req_q;
  logic take;
  logic hit_ext;
  logic hit_ctrl;
  logic bad_access;
  logic go_ext;
  logic beat_idx;
  logic last_beat;
  logic ws_start;
  logic ws_write;
  logic ws_busy;
  logic ws_done;
  logic [3:0] beat_len;

  assign take = req_valid_in && req_ready_out;

  // window decode on byte addresses for either core variant
  always_comb begin
    if (cpu_wide_in) begin
      hit_ext = in_window(req_in.addr, EXT32_LO, EXT32_HI); // [RULE13] [RULE1]
      hit_ctrl = in_window(req_in.addr, CTRL32_LO, CTRL32_HI); // [RULE14]
    end else begin
      hit_ext = in_window(req_in.addr, EXT8_LO, EXT8_HI); // [RULE11] [RULE1]
      hit_ctrl = in_window(req_in.addr, CTRL8_LO, CTRL8_HI); // [RULE12]
    end
  end

  // byte and unaligned accesses cannot be carried on a 16-bit memory
  always_comb begin
    bad_access = 1'b0;
    if (mem_width16_in) begin
      unique case (req_in.size)
        SZ_BYTE: bad_access = 1'b1; // [RULE6]
        SZ_HALF: bad_access = req_in.addr[0]; // [RULE8]
        default: bad_access = (req_in.addr[1:0] != 2'b00); // [RULE8]
      endcase
    end
  end

  assign go_ext = take && hit_ext && !bad_access;

  // a beat starts on acceptance and again for the second word
  assign ws_start = go_ext || ((state == ST_BEAT) && ws_done && !last_beat);
  assign ws_write = go_ext ? req_in.write : req_q.write;

  ext_mem_wait_counter u_wait (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(ws_start),
    .write_in(ws_write),
    .div_in(clk_div_in),
    .busy_out(ws_busy),
    .done_out(ws_done)
  );

  // ***************************************************************
  // sequencing
  // ***************************************************************
  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = go_ext ? ST_BEAT : ST_RESP;
        end
      end
      ST_BEAT: begin
        if (ws_done && last_beat) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // state register and ready
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      req_ready_out <= 1'b1;
    end else begin
      state <= next_state;
      req_ready_out <= (next_state == ST_IDLE);
    end
  end

  // request capture and beat bookkeeping
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_q <= '0;
      beat_idx <= 1'b0;
      last_beat <= 1'b1;
    end else if (take) begin
      req_q <= req_in;
      beat_idx <= 1'b0;
      // a wide word splits into two words; on 8-bit memory nothing splits
      last_beat <= !(mem_width16_in && (req_in.size == SZ_WORD)); // [RULE10]
    end else if ((state == ST_BEAT) && ws_done && !last_beat) begin
      beat_idx <= 1'b1;
      last_beat <= 1'b1;
    end
  end

  // ***************************************************************
  // memory side
  // ***************************************************************
  // address, strobe and write data per beat
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_addr_out <= 24'h00_0000;
      mem_strobe_out <= 1'b0;
      mem_write_out <= 1'b0;
      data_lo_out <= 8'h00;
      data_hi_out <= 8'h00;
      data_lo_oe_out <= 1'b0;
      data_hi_oe_out <= 1'b0;
    end else if (go_ext) begin
      mem_addr_out <= req_in.addr[MEM_ADDR_W-1:0]; // [RULE2] [RULE3]
      mem_strobe_out <= 1'b1;
      mem_write_out <= req_in.write;
      data_lo_out <= req_in.wdata[7:0]; // [RULE16]
      data_hi_out <= req_in.wdata[15:8]; // [RULE16]
      data_lo_oe_out <= req_in.write;
      data_hi_oe_out <= req_in.write && mem_width16_in; // [RULE5]
    end else if ((state == ST_BEAT) && ws_done) begin
      if (!last_beat) begin
        mem_addr_out <= mem_addr_out + ADDR_STEP16; // [RULE4]
        data_lo_out <= req_q.wdata[23:16];
        data_hi_out <= req_q.wdata[31:24];
      end else begin
        mem_strobe_out <= 1'b0;
        mem_write_out <= 1'b0;
        data_lo_oe_out <= 1'b0;
        data_hi_oe_out <= 1'b0;
      end
    end
  end

  // read data gathered from the ports at the end of each beat
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_rdata_out <= 32'h0000_0000;
    end else if (take) begin
      resp_rdata_out <= 32'h0000_0000;
    end else if ((state == ST_BEAT) && ws_done && !req_q.write) begin
      if (mem_width16_in) begin
        resp_rdata_out[{beat_idx, 4'h0} +: 16] <= {data_hi_in, data_lo_in}; // [RULE16]
      end else begin
        resp_rdata_out[7:0] <= data_lo_in; // [RULE10]
      end
    end
  end

  // ***************************************************************
  // answer and control window
  // ***************************************************************
  // one-cycle answer, error on a miss or an illegal access
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_valid_out <= 1'b0;
      resp_error_out <= 1'b0;
    end else begin
      resp_valid_out <= (next_state == ST_RESP);
      if (take) begin
        resp_error_out <= hit_ext ? bad_access : !hit_ctrl; // [RULE6] [RULE8]
      end
    end
  end

  // control register access strobe
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_access_out <= 1'b0;
      ctrl_write_out <= 1'b0;
      ctrl_offset_out <= 8'h00;
      ctrl_wdata_out <= 8'h00;
    end else begin
      ctrl_access_out <= take && hit_ctrl; // [RULE12] [RULE14]
      if (take && hit_ctrl) begin
        ctrl_write_out <= req_in.write;
        ctrl_offset_out <= req_in.addr[7:0];
        ctrl_wdata_out <= req_in.wdata[7:0];
      end
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  // cycles elapsed in the current beat
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      beat_len <= 4'h0;
    end else if (ws_start) begin
      beat_len <= 4'h0;
    end else if (ws_busy) begin
      beat_len <= beat_len + 4'h1;
    end
  end

  ext8_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE11]
    (take && !cpu_wide_in && (req_in.addr[31:23] == 9'h001)) |-> hit_ext)
    else $error("upper half not decoded as external memory");
  ctrl8_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE12]
    (take && !cpu_wide_in && (req_in.addr[31:8] == 24'h00_0054))
      |=> ctrl_access_out && (ctrl_offset_out == $past(req_in.addr[7:0])))
    else $error("narrow control window missed");
  ext32_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE13]
    (take && cpu_wide_in && (req_in.addr[31:24] == 8'h60) && !bad_access)
      |=> (state == ST_BEAT) && mem_strobe_out)
    else $error("external ram window not started");
  ctrl32_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE14]
    (take && cpu_wide_in && (req_in.addr[31:8] == 24'h40_0054)) |=> ctrl_access_out)
    else $error("wide control window missed");
  addr_step_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE4]
    $rose(beat_idx) |-> (mem_addr_out == $past(mem_addr_out) + ADDR_STEP16))
    else $error("second word not two bytes on");
  byte16_reject_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE6]
    (take && mem_width16_in && hit_ext && (req_in.size == SZ_BYTE))
      |=> resp_valid_out && resp_error_out && !mem_strobe_out)
    else $error("byte access reached 16-bit memory");
  wait_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE15]
    ws_done |-> (beat_len == waits_for(clk_div_in, req_q.write)))
    else $error("beat length differs from wait states");
  narrow_single_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE10]
    (go_ext && !mem_width16_in) |=> last_beat && !data_hi_oe_out)
    else $error("narrow memory access was split");
  low_lane_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // [RULE16]
    (go_ext && req_in.write && mem_width16_in)
      |=> (data_lo_out == $past(req_in.wdata[7:0])) && data_hi_oe_out)
    else $error("even byte not on low data port");
endmodule
`default_nettype wire

// ---- ext_mem_model.sv ----
// behavioural external memory partner, eight or sixteen bits wide
`default_nettype none
module ext_mem_model (
  // memory pins
  input wire logic clk_in,
  input wire logic width16_in,
  input wire logic [23:0] addr_in,
  input wire logic strobe_in,
  input wire logic write_in,
  input wire logic [7:0] d_lo_in,
  input wire logic [7:0] d_hi_in,
  output logic [7:0] q_lo_out,
  output logic [7:0] q_hi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [logic [23:0]];
  logic [15:0] last = 16'ha5c3;
  logic [23:0] lo_a;
  logic rd;
  // a wide part sees line one as its lowest input, so bit 0 is ignored
  assign lo_a = width16_in ? {addr_in[23:1], 1'b0} : addr_in;
  assign rd = strobe_in && !write_in;
  // unwritten cells read as zero
  function automatic logic [7:0] rd8(input logic [23:0] a);
    return m.exists(a) ? m[a] : 8'h00;
  endfunction
  // store the low port byte at the addressed cell; a wide part also stores the odd byte from the high port
  always @(posedge clk_in) begin
    if (strobe_in && write_in) begin
      m[lo_a] = d_lo_in;
      if (width16_in) begin
        m[lo_a | 24'h1] = d_hi_in;
      end
    end
    if (rd) begin
      last = {q_hi_out, q_lo_out};
    end
  end
  // read drive; lines not driven show the inverse of their last value
  always @* begin
    q_lo_out = rd ? rd8(lo_a) : ~last[7:0];
    q_hi_out = (rd && width16_in) ? rd8(lo_a | 24'h1) : ~last[15:8];
  end
endmodule
`default_nettype wire

// ---- test_ext_mem_width_adapter.sv ----
// self-checking bench for the external memory width adapter
`default_nettype none
module test_ext_mem_width_adapter import ext_mem_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic w16 = 1'b0;
  logic wide = 1'b1;
  logic [1:0] div = 2'h0;
  logic valid = 1'b0;
  hub_req_t rq = '0;
  logic ready, rv, rerr, cacc, cwr, mstb, mwr, lo_oe, hi_oe;
  logic [31:0] rdata;
  logic [7:0] coff, cwd, lo_o, hi_o, q_lo, q_hi, lo_i, hi_i;
  logic [23:0] maddr, last_a;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  // ******************************************
  // clock, pins and instances
  // ******************************************
  initial begin
    forever #2 clk = ~clk;
  end
  // wire level: whoever enables its driver owns the pin
  assign lo_i = lo_oe ? lo_o : q_lo;
  assign hi_i = hi_oe ? hi_o : q_hi;
  ext_mem_width_adapter u_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .mem_width16_in(w16),
    .cpu_wide_in(wide), .clk_div_in(div), .req_valid_in(valid), .req_in(rq),
    .req_ready_out(ready), .resp_valid_out(rv), .resp_error_out(rerr),
    .resp_rdata_out(rdata), .ctrl_access_out(cacc), .ctrl_write_out(cwr),
    .ctrl_offset_out(coff), .ctrl_wdata_out(cwd), .mem_addr_out(maddr),
    .mem_strobe_out(mstb), .mem_write_out(mwr), .data_lo_in(lo_i), .data_lo_out(lo_o),
    .data_lo_oe_out(lo_oe), .data_hi_in(hi_i), .data_hi_out(hi_o), .data_hi_oe_out(hi_oe));
  ext_mem_model u_mem (.clk_in(clk), .width16_in(w16), .addr_in(maddr), .strobe_in(mstb),
    .write_in(mwr), .d_lo_in(lo_o), .d_hi_in(hi_o), .q_lo_out(q_lo), .q_hi_out(q_hi));
  // ******************************************
  // shared tasks
  // ******************************************
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // one hub request; judges latency, error, strobe and control hit
  task automatic req(input logic [31:0] a, input logic wr, input logic [1:0] sz,
      input logic [31:0] wd, input int lat, input logic err, input logic ctl);
    int n;
    logic stb;
    logic acc;
    n = 0;
    stb = 1'b0;
    acc = 1'b0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    valid = 1'b1;
    rq = '{addr: a, write: wr, size: sz, wdata: wd};
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    // a miss or control hit already answers in the cycle right after the take edge
    stb = (mstb === 1'b1);
    acc = (cacc === 1'b1);
    if (mstb === 1'b1) last_a = maddr;
    while (rv !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
      stb |= (mstb === 1'b1);
      acc |= (cacc === 1'b1);
      if (mstb === 1'b1) last_a = maddr;
    end
    chk(n == lat, "answer latency");
    chk(rerr === err, "error flag");
    chk(stb == (lat > 1), "memory strobe");
    chk(acc == ctl, "control hit");
  endtask
  // ******************************************
  // scenarios
  // ******************************************
  task automatic t_decode();
    w16 = 1'b0;
    wide = 1'b1;
    req(32'h4000_5400, 1'b0, SZ_BYTE, 32'h0, 0, 1'b0, 1'b1);
    chk(coff === 8'h00, "ctrl offset low");
    req(32'h4000_54ff, 1'b1, SZ_BYTE, 32'h5a, 0, 1'b0, 1'b1);
    chk(coff === 8'hff && cwd === 8'h5a && cwr === 1'b1, "ctrl write");
    req(32'h4000_5500, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    req(32'h60ff_ffff, 1'b0, SZ_BYTE, 32'h0, 2, 1'b0, 1'b0);
    chk(last_a === 24'hff_ffff, "top of window");
    req(32'h6100_0000, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    req(32'h5fff_ffff, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    wide = 1'b0;
    req(32'h0000_5410, 1'b0, SZ_BYTE, 32'h0, 0, 1'b0, 1'b1);
    chk(coff === 8'h10, "ctrl offset");
    req(32'h0000_5500, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    req(32'h0080_0000, 1'b1, SZ_BYTE, 32'h77, 3, 1'b0, 1'b0);
    chk(last_a === 24'h80_0000, "upper half base");
    req(32'h007f_ffff, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    req(32'h0100_0000, 1'b0, SZ_BYTE, 32'h0, 0, 1'b1, 1'b0);
    req(32'h0080_0000, 1'b0, SZ_BYTE, 32'h0, 2, 1'b0, 1'b0);
    chk(rdata === 32'h77, "upper half read back");
  endtask
  task automatic t_width8();
    logic [31:0] a;
    w16 = 1'b0;
    wide = 1'b1;
    for (int d = 0; d < 4; d++) begin
      div = 2'(d);
      a = 32'h6080_0010 + 32'(d);
      req(a, 1'b1, SZ_WORD, 32'hcafe_0040 + 32'(d), 2 * d + 3, 1'b0, 1'b0);
      chk(last_a === a[23:0], "byte address lines");
      req(a, 1'b0, SZ_WORD, 32'h0, 2 * d + 2, 1'b0, 1'b0);
      chk(rdata === 32'h40 + 32'(d), "byte read back");
    end
    div = 2'h0;
    req(32'h6000_0021, 1'b1, SZ_BYTE, 32'h11, 3, 1'b0, 1'b0);
    req(32'h6000_0020, 1'b1, SZ_HALF, 32'hbbaa, 3, 1'b0, 1'b0);
    req(32'h6000_0021, 1'b0, SZ_BYTE, 32'h0, 2, 1'b0, 1'b0);
    chk(rdata === 32'h11, "neighbour byte kept");
    chk(u_mem.m[24'h20] === 8'haa, "low byte of half");
  endtask
  task automatic t_width16();
    w16 = 1'b1;
    wide = 1'b1;
    div = 2'h0;
    req(32'h6000_0100, 1'b1, SZ_WORD, 32'h4433_2211, 6, 1'b0, 1'b0);
    chk(last_a === 24'h00_0102, "second word address");
    chk(u_mem.m[24'h100] === 8'h11 && u_mem.m[24'h101] === 8'h22, "byte lanes");
    chk(u_mem.m[24'h103] === 8'h44, "upper half at plus two");
    req(32'h6000_0100, 1'b0, SZ_WORD, 32'h0, 4, 1'b0, 1'b0);
    chk(rdata === 32'h4433_2211, "word read back");
    req(32'h6000_0102, 1'b0, SZ_HALF, 32'h0, 2, 1'b0, 1'b0);
    chk(rdata === 32'h0000_4433, "half read back");
    req(32'h6000_0102, 1'b1, SZ_HALF, 32'h6655, 3, 1'b0, 1'b0);
    req(32'h6000_0100, 1'b1, SZ_BYTE, 32'h99, 0, 1'b1, 1'b0);
    req(32'h6000_0101, 1'b0, SZ_HALF, 32'h0, 0, 1'b1, 1'b0);
    req(32'h6000_0102, 1'b0, SZ_WORD, 32'h0, 0, 1'b1, 1'b0);
    req(32'h6000_0100, 1'b0, SZ_WORD, 32'h0, 4, 1'b0, 1'b0);
    chk(rdata === 32'h6655_2211, "byte write refused");
  endtask
  // ******************************************
  // run control
  // ******************************************
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_decode();
    t_width8();
    t_width16();
    wrap_up();
  end
endmodule
`default_nettype wire
